// ==== design/tone_pkg.sv ====
package tone_pkg;

    localparam int CLK_PERIOD_NS = 40;
    localparam int MS_NS         = 1_000_000;
    // ms prescale, above 4096 so the top exposes it as a parameter
    localparam int MS_CYCLES_DEF = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FADE_MS       = 64;

    localparam int NUM_EVENTS    = 10;
    localparam int NUM_VOICES    = 6;
    localparam int PURE_VOICES   = 4;
    localparam int CFG_ENTRIES   = NUM_EVENTS * NUM_VOICES;
    localparam int FIFO_DEPTH    = 8;

    localparam int AUDIO_W       = 20;
    localparam int TONE_W        = 16;
    localparam int TIME_W        = 12;
    localparam int MIX_W         = 24;
    localparam int ATTEN_SHIFT   = 2;
    localparam int TONE_UPSHIFT  = AUDIO_W - TONE_W;

    localparam logic [8:0]  ENV_FULL   = 9'h100;
    localparam logic [16:0] DAMP_START = 17'h10000;

    // event index on event_req
    localparam int EVT_MEM_A        = 0;
    localparam int EVT_MEM_B        = 1;
    localparam int EVT_MEM_C        = 2;
    localparam int EVT_MEM_D        = 3;
    localparam int EVT_MEM_E        = 4;
    localparam int EVT_MEM_F        = 5;
    localparam int EVT_LOW_BATTERY  = 6;
    localparam int EVT_VOLUME_KNOB  = 7;
    localparam int EVT_KNOB_MIN     = 8;
    localparam int EVT_KNOB_MAX     = 9;

    typedef struct packed {
        logic [15:0]       freq_inc;
        logic [7:0]        amp;
        logic [TIME_W-1:0] start_ms;
        logic [TIME_W-1:0] dur_ms;
        logic [3:0]        decay_shift;
    } voice_cfg_t;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_PLAY = 1'b1
    } play_state_t;

endpackage

// ==== design/sample_fifo.sv ====
`timescale 1ns/1ns
module sample_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_ff;
    logic [AW-1:0]    rd_ptr_ff;
    logic [CW-1:0]    count_ff;
    logic [CW-1:0]    nxt_count;
    logic             ready_ff;
    logic             push;
    logic             pop;

    assign push      = in_valid && ready_ff;
    assign pop       = out_valid && out_ready;
    assign out_valid = (count_ff != '0);
    assign out_data  = mem[rd_ptr_ff];
    assign in_ready  = ready_ff;
    assign nxt_count = count_ff + CW'(push) - CW'(pop);

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_ff] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
            ready_ff  <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
            end
            count_ff <= nxt_count;
            // registered so the port is a flop; full stalls the source
            ready_ff <= (nxt_count < CW'(DEPTH));
        end
    end
endmodule

// ==== design/tone_voice.sv ====
`timescale 1ns/1ns
module tone_voice (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 restart,
    input  wire logic                 ms_tick,
    input  wire logic                 sample_tick,
    input  wire logic                 enable,
    input  wire logic                 damped,
    input  tone_pkg::voice_cfg_t      cfg,
    output logic signed [15:0]        sample,
    output logic                      done
);
    import tone_pkg::*;

    // one bit wider than start or duration, so start plus duration is always reachable
    logic [TIME_W:0]    t_ff;
    logic [15:0]        phase_ff;
    logic [16:0]        env_ff;
    logic signed [15:0] sample_ff;
    logic [TIME_W:0]    end_t;
    logic [TIME_W:0]    rel;
    logic [TIME_W:0]    rem;
    logic [TIME_W:0]    edge_dist;
    logic [8:0]         pure_gain;
    logic [8:0]         gain;
    logic               active;
    logic [31:0]        sq;
    logic signed [16:0] sine;
    logic signed [25:0] p1;
    logic signed [27:0] p2;

    assign end_t  = {1'b0, cfg.start_ms} + {1'b0, cfg.dur_ms};
    assign active = enable && (t_ff >= {1'b0, cfg.start_ms}) && (t_ff < end_t);
    assign done   = !enable || (t_ff >= end_t);
    assign sample = sample_ff;

    assign rel = t_ff - {1'b0, cfg.start_ms};
    assign rem = end_t - t_ff;
    assign edge_dist = (rel < rem) ? rel : rem;

    always_comb begin
        pure_gain = ENV_FULL;
        if (edge_dist < (TIME_W+1)'(FADE_MS)) begin
            pure_gain = 9'((edge_dist * ENV_FULL) / FADE_MS);
        end
    end

    assign gain = damped ? env_ff[16:8] : pure_gain;

    // parabolic half-wave, close to a sine and cheap
    assign sq   = {17'h00000, phase_ff[14:0]} * (32'h00008000 - {17'h00000, phase_ff[14:0]});
    assign sine = phase_ff[15] ? -$signed({1'b0, sq[29:14]}) : $signed({1'b0, sq[29:14]});
    assign p1   = sine * $signed({1'b0, cfg.amp});
    assign p2   = $signed(p1[25:8]) * $signed({1'b0, gain});

    always_ff @(posedge clk) begin
        if (!rst_n || restart) begin
            t_ff <= '0;
        end else if (ms_tick && (t_ff != '1)) begin
            t_ff <= t_ff + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || restart) begin
            phase_ff <= '0;
        end else if (sample_tick && active) begin
            phase_ff <= phase_ff + cfg.freq_inc;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || restart) begin
            env_ff <= DAMP_START;
        end else if (t_ff < {1'b0, cfg.start_ms}) begin
            env_ff <= DAMP_START;
        end else if (ms_tick) begin
            env_ff <= env_ff - (env_ff >> cfg.decay_shift);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sample_ff <= '0;
        end else if (sample_tick) begin
            sample_ff <= active ? p2[23:8] : '0;
        end
    end
endmodule

// ==== design/indicator_tone_gen.sv ====
// Operation
// - each of the ten events (memories A-F, low battery, knob move, knob min, knob max) has its own stored sound.
// - a stored sound is either all pure tones or all damped tones, chosen by one mode bit per sound.
// - a pure-tone sound uses at most four voices, each with frequency, amplitude, duration and start.
// - every pure voice fades in and out over 64 ms.
// - a pure voice's start time is where its fade-in begins, counted from the sound's start.
// - a pure voice's duration is counted from the start of its fade-in.
// - a damped sound uses at most six voices, each also with a decay time.
// - a damped voice starts at full level with no ramp and then decays exponentially.
// - while a sound plays the main audio is attenuated, not muted, and summed with the tones.
`timescale 1ns/1ns
module indicator_tone_gen #(
    parameter int MS_CYCLES = tone_pkg::MS_CYCLES_DEF
) (
    input  wire logic                                clk,
    input  wire logic                                rst_n,
    input  wire logic [tone_pkg::NUM_EVENTS-1:0]     event_req,
    input  wire logic                                cfg_voice_we,
    input  wire logic [3:0]                          cfg_sound,
    input  wire logic [2:0]                          cfg_voice,
    input  tone_pkg::voice_cfg_t                     cfg_voice_data,
    input  wire logic                                cfg_mode_we,
    input  wire logic                                cfg_damped,
    input  wire logic signed [tone_pkg::AUDIO_W-1:0] audio_in,
    input  wire logic                                audio_in_valid,
    output logic                                     audio_in_ready,
    output logic signed [tone_pkg::AUDIO_W-1:0]      audio_out,
    output logic                                     audio_out_valid,
    input  wire logic                                audio_out_ready,
    output logic                                     playing,
    output logic [3:0]                               sound_id
);
    import tone_pkg::*;

    voice_cfg_t                 cfg_mem [CFG_ENTRIES];
    logic [NUM_EVENTS-1:0]      damped_mem_ff;
    logic [5:0]                 wr_idx;

    play_state_t                st_ff;
    logic                       playing_ff;
    logic [3:0]                 sound_ff;
    logic                       start_ff;
    logic                       act_damped_ff;
    voice_cfg_t                 act_cfg_ff [NUM_VOICES];

    logic                       evt_hit;
    logic [3:0]                 evt_idx;

    logic [15:0]                ms_cnt_ff;
    logic                       ms_tick_ff;

    logic [NUM_VOICES-1:0]      voice_en;
    logic [NUM_VOICES-1:0]      voice_done;
    logic signed [TONE_W-1:0]   voice_smp [NUM_VOICES];

    logic                       fifo_valid;
    logic signed [AUDIO_W-1:0]  fifo_data;
    logic                       pop;
    logic                       advance;
    logic                       s1_valid_ff;
    logic signed [AUDIO_W-1:0]  s1_audio_ff;
    logic                       s1_playing_ff;

    logic signed [MIX_W-1:0]    ind_sum;
    logic signed [MIX_W-1:0]    main_part;
    logic signed [MIX_W-1:0]    mix;
    logic signed [AUDIO_W-1:0]  out_ff;
    logic                       out_valid_ff;

    function automatic logic signed [AUDIO_W-1:0] saturate(input logic signed [MIX_W-1:0] x);
        logic signed [MIX_W-1:0] hi;
        logic signed [MIX_W-1:0] lo;
        hi = MIX_W'({1'b0, {(AUDIO_W-1){1'b1}}});
        lo = -hi - MIX_W'(1);
        if (x > hi) begin
            saturate = {1'b0, {(AUDIO_W-1){1'b1}}};
        end else if (x < lo) begin
            saturate = {1'b1, {(AUDIO_W-1){1'b0}}};
        end else begin
            saturate = x[AUDIO_W-1:0];
        end
    endfunction

    assign playing         = playing_ff;
    assign sound_id        = sound_ff;
    assign audio_out       = out_ff;
    assign audio_out_valid = out_valid_ff;

    // sound storage, written from the configuration port

    assign wr_idx = 6'(cfg_sound) * 6'(NUM_VOICES) + 6'(cfg_voice);

    always_ff @(posedge clk) begin
        if (cfg_voice_we && (cfg_sound < 4'(NUM_EVENTS)) && (cfg_voice < 3'(NUM_VOICES))) begin
            cfg_mem[wr_idx] <= cfg_voice_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            damped_mem_ff <= '0;
        end else if (cfg_mode_we && (cfg_sound < 4'(NUM_EVENTS))) begin
            damped_mem_ff[cfg_sound] <= cfg_damped;
        end
    end

    // event selection, lowest index wins on a tie

    always_comb begin
        evt_hit = 1'b0;
        evt_idx = '0;
        for (int i = NUM_EVENTS - 1; i >= 0; i--) begin
            if (event_req[i]) begin
                evt_hit = 1'b1;
                evt_idx = 4'(i);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_ff         <= ST_IDLE;
            playing_ff    <= 1'b0;
            sound_ff      <= '0;
            start_ff      <= 1'b0;
            act_damped_ff <= 1'b0;
        end else begin
            start_ff <= evt_hit;
            case (st_ff)
                ST_IDLE: begin
                    if (evt_hit) begin
                        st_ff      <= ST_PLAY;
                        playing_ff <= 1'b1;
                    end
                end
                ST_PLAY: begin
                    // done flags are stale in the cycle the voices restart
                    if (!evt_hit && !start_ff && (&voice_done)) begin
                        st_ff      <= ST_IDLE;
                        playing_ff <= 1'b0;
                    end
                end
                default: begin
                    st_ff      <= ST_IDLE;
                    playing_ff <= 1'b0;
                end
            endcase
            if (evt_hit) begin
                sound_ff      <= evt_idx;
                act_damped_ff <= damped_mem_ff[evt_idx];
            end
        end
    end

    // snapshot so config writes cannot disturb a playing sound
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int v = 0; v < NUM_VOICES; v++) begin
                act_cfg_ff[v] <= '0;
            end
        end else if (evt_hit) begin
            for (int v = 0; v < NUM_VOICES; v++) begin
                act_cfg_ff[v] <= cfg_mem[6'(evt_idx) * 6'(NUM_VOICES) + 6'(v)];
            end
        end
    end

    // millisecond time base, aligned to the sound start

    always_ff @(posedge clk) begin
        if (!rst_n || evt_hit) begin
            ms_cnt_ff  <= '0;
            ms_tick_ff <= 1'b0;
        end else begin
            ms_tick_ff <= (ms_cnt_ff == 16'(MS_CYCLES - 1));
            if (ms_cnt_ff == 16'(MS_CYCLES - 1)) begin
                ms_cnt_ff <= '0;
            end else begin
                ms_cnt_ff <= ms_cnt_ff + 16'h0001;
            end
        end
    end

    // voices

    for (genvar v = 0; v < NUM_VOICES; v++) begin : g_voice
        assign voice_en[v] = playing_ff && (act_damped_ff || (v < PURE_VOICES))
                             && (act_cfg_ff[v].amp != 8'h00);

        tone_voice u_voice (
            .clk         (clk),
            .rst_n       (rst_n),
            .restart     (start_ff),
            .ms_tick     (ms_tick_ff),
            .sample_tick (pop),
            .enable      (voice_en[v]),
            .damped      (act_damped_ff),
            .cfg         (act_cfg_ff[v]),
            .sample      (voice_smp[v]),
            .done        (voice_done[v])
        );
    end

    // audio path

    sample_fifo #(
        .WIDTH (AUDIO_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (audio_in_valid),
        .in_ready  (audio_in_ready),
        .in_data   (audio_in),
        .out_valid (fifo_valid),
        .out_ready (pop),
        .out_data  (fifo_data)
    );

    // one tone sample per audio sample
    assign advance = s1_valid_ff && (!out_valid_ff || audio_out_ready);
    assign pop     = fifo_valid && !s1_valid_ff && (!out_valid_ff || audio_out_ready);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_valid_ff   <= 1'b0;
            s1_audio_ff   <= '0;
            s1_playing_ff <= 1'b0;
        end else if (pop) begin
            s1_valid_ff   <= 1'b1;
            s1_audio_ff   <= fifo_data;
            s1_playing_ff <= playing_ff;
        end else if (advance) begin
            s1_valid_ff <= 1'b0;
        end
    end

    always_comb begin
        ind_sum = '0;
        for (int v = 0; v < NUM_VOICES; v++) begin
            ind_sum = ind_sum + (MIX_W'(voice_smp[v]) <<< TONE_UPSHIFT);
        end
    end

    assign main_part = s1_playing_ff ? (MIX_W'(s1_audio_ff) >>> ATTEN_SHIFT) : MIX_W'(s1_audio_ff);
    assign mix       = main_part + ind_sum;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            out_ff       <= '0;
            out_valid_ff <= 1'b0;
        end else if (advance) begin
            out_ff       <= saturate(mix);
            out_valid_ff <= 1'b1;
        end else if (audio_out_ready) begin
            out_valid_ff <= 1'b0;
        end
    end
endmodule

// ==== verif/indicator_tone_gen_props.sv ====
`timescale 1ns/1ns
module indicator_tone_gen_checker
    import tone_pkg::*;
#(
    parameter int MS_CYCLES = 4
) (
    input wire logic                                clk,
    input wire logic                                rst_n,
    input wire logic [tone_pkg::NUM_EVENTS-1:0]     event_req,
    input wire logic                                audio_in_valid,
    input wire logic                                audio_in_ready,
    input wire logic signed [tone_pkg::AUDIO_W-1:0] audio_out,
    input wire logic                                audio_out_valid,
    input wire logic                                audio_out_ready,
    input wire logic                                playing,
    input wire logic [3:0]                          sound_id
);
    // longest start plus duration, plus a few cycles of pipeline
    localparam int PLAY_MAX = 8190 * MS_CYCLES + 8;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [3:0] first_idx;
    logic       in_take;
    logic       out_take;
    int         pend_ff;
    int         since_ff;
    assign in_take  = audio_in_valid && audio_in_ready;
    assign out_take = audio_out_valid && audio_out_ready;
    // lowest set bit wins a tie
    always_comb begin
        first_idx = 4'h0;
        for (int i = NUM_EVENTS - 1; i >= 0; i--) begin
            if (event_req[i]) begin
                first_idx = 4'(i);
            end
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pend_ff <= 0;
        end else begin
            pend_ff <= pend_ff + int'(in_take) - int'(out_take);
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n || |event_req) begin
            since_ff <= 0;
        end else if (playing) begin
            since_ff <= since_ff + 1;
        end
    end
    a_event_starts_play: assert property (|event_req |=> playing)
        else $error("playing not raised after event");
    a_event_sound_id: assert property (|event_req |=> sound_id == $past(first_idx))
        else $error("sound_id not the requested event");
    a_id_holds_idle: assert property (!(|event_req) |=> $stable(sound_id))
        else $error("sound_id changed without event");
    a_play_has_cause: assert property ($rose(playing) |-> $past(|event_req))
        else $error("playing rose without event");
    a_play_ends_bound: assert property (playing |-> since_ff <= PLAY_MAX)
        else $error("sound outlived its longest voice");
    a_out_stands_stall: assert property (audio_out_valid && !audio_out_ready |=> audio_out_valid && $stable(audio_out))
        else $error("output sample dropped or changed under stall");
    a_out_has_input: assert property (out_take |-> pend_ff > 0)
        else $error("output sample without input sample");
    a_out_min_latency: assert property (in_take && pend_ff == 0 |=> !audio_out_valid [*2])
        else $error("output sample too early");
    a_buffer_bounded: assert property (pend_ff <= FIFO_DEPTH + 2)
        else $error("more samples held than buffer and stages");
    c_event: cover property (|event_req ##1 playing);
    c_out_stall: cover property (audio_out_valid && !audio_out_ready);
    c_in_full: cover property (!audio_in_ready);
endmodule
bind indicator_tone_gen indicator_tone_gen_checker #(.MS_CYCLES(MS_CYCLES)) i_indicator_tone_gen_checker (
    .clk(clk), .rst_n(rst_n), .event_req(event_req), .audio_in_valid(audio_in_valid),
    .audio_in_ready(audio_in_ready), .audio_out(audio_out), .audio_out_valid(audio_out_valid),
    .audio_out_ready(audio_out_ready), .playing(playing), .sound_id(sound_id));

// ==== verif/audio_path_model.sv ====
`timescale 1ns/1ns
module audio_path_model
    import tone_pkg::*;
(
    input wire logic                                clk,
    output logic signed [tone_pkg::AUDIO_W-1:0]     audio_in,
    output logic                                    audio_in_valid,
    input wire logic                                audio_in_ready,
    output logic                                    audio_out_ready,
    input wire logic [1:0]                          sink_mode
);
    initial begin
        audio_in        = '0;
        audio_in_valid  = 1'b0;
        audio_out_ready = 1'b0;
    end
    // 0 prompt, 1 random stalls, 2 stalled
    always @(posedge clk) begin
        audio_out_ready <= #1 (sink_mode == 2'h0) || (sink_mode == 2'h1 && $urandom_range(2) == 0);
    end
    // caller is just after an edge; one idle cycle between samples
    task automatic send(input logic signed [AUDIO_W-1:0] s, output logic ok);
        int n;
        n = 0;
        audio_in       <= s;
        audio_in_valid <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (audio_in_ready !== 1'b1 && n < 500);
        ok = (n < 500);
        #1;
        audio_in_valid <= 1'b0;
        // released data must not look like a held sample
        audio_in       <= ~s;
        @(posedge clk);
        #1;
    endtask
endmodule

// ==== verif/indicator_tone_gen_test.sv ====
`timescale 1ns/1ns
module indicator_tone_gen_test;
    import tone_pkg::*;
    localparam int MSC = 4;
    logic                      clk;
    logic                      rst_n;
    logic [NUM_EVENTS-1:0]     event_req;
    logic                      cfg_voice_we;
    logic                      cfg_mode_we;
    logic                      cfg_damped;
    logic [3:0]                cfg_sound;
    logic [2:0]                cfg_voice;
    voice_cfg_t                cfg_voice_data;
    logic signed [AUDIO_W-1:0] audio_in;
    logic signed [AUDIO_W-1:0] audio_out;
    logic                      audio_in_valid;
    logic                      audio_in_ready;
    logic                      audio_out_valid;
    logic                      audio_out_ready;
    logic                      playing;
    logic [3:0]                sound_id;
    logic [1:0]                sink_mode;
    logic                      att;
    int                        fails;
    int                        checked;
    logic [AUDIO_W-1:0]        exp_q[$];

    indicator_tone_gen #(.MS_CYCLES(MSC)) i_indicator_tone_gen (.clk, .rst_n, .event_req, .cfg_voice_we,
        .cfg_sound, .cfg_voice, .cfg_voice_data, .cfg_mode_we, .cfg_damped, .audio_in, .audio_in_valid,
        .audio_in_ready, .audio_out, .audio_out_valid, .audio_out_ready, .playing, .sound_id);
    audio_path_model i_audio_path_model (.clk, .audio_in, .audio_in_valid, .audio_in_ready,
        .audio_out_ready, .sink_mode);

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic chk(input string what, input logic [AUDIO_W-1:0] e, input logic [AUDIO_W-1:0] s);
        checked++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, e, s);
        end
    endtask

    task automatic complete_run;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input int s, input int v, input int a, input int st, input int du);
        cfg_sound      <= 4'(s);
        cfg_voice      <= 3'(v);
        cfg_voice_data <= '{16'h0000, 8'(a), 12'(st), 12'(du), 4'h2};
        cfg_voice_we   <= 1'b1;
        tick(1);
        cfg_voice_we   <= 1'b0;
        tick(1);
    endtask

    task automatic wr_mode(input int s, input logic dm);
        cfg_sound   <= 4'(s);
        cfg_damped  <= dm;
        cfg_mode_we <= 1'b1;
        tick(1);
        cfg_mode_we <= 1'b0;
        tick(1);
    endtask

    task automatic fire(input logic [NUM_EVENTS-1:0] m, input logic [3:0] id);
        event_req <= m;
        tick(1);
        event_req <= '0;
        chk("playing", 1, AUDIO_W'(playing));
        chk("sound_id", AUDIO_W'(id), AUDIO_W'(sound_id));
        tick(1);
    endtask

    task automatic push(input logic signed [AUDIO_W-1:0] s);
        logic ok;
        exp_q.push_back(att ? AUDIO_W'(s >>> ATTEN_SHIFT) : s);
        i_audio_path_model.send(s, ok);
        chk("in_taken", 1, AUDIO_W'(ok));
    endtask

    task automatic drain;
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 3000) begin
            tick(1);
            n++;
        end
        chk("drained", 0, AUDIO_W'(exp_q.size()));
    endtask

    always @(posedge clk) begin
        if (rst_n === 1'b1 && audio_out_valid === 1'b1 && audio_out_ready === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk("spare_out", 0, 1);
            end else begin
                chk("audio_out", exp_q.pop_front(), audio_out);
            end
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        $display("[ERR] watchdog expected done seen timeout");
        complete_run();
    end

    initial begin
        void'($urandom(32'h4A0C239D));
        {event_req, cfg_voice_we, cfg_mode_we, cfg_damped, cfg_sound, cfg_voice} = '0;
        cfg_voice_data = '0;
        sink_mode = 2'h0;
        att = 1'b0;
        rst_n = 1'b0;
        tick(4);
        chk("rst_valid", 0, AUDIO_W'(audio_out_valid));
        chk("rst_playing", 0, AUDIO_W'(playing));
        rst_n = 1'b1;
        for (int s = 0; s < NUM_EVENTS; s++) begin
            for (int v = 0; v < NUM_VOICES; v++) begin
                wr(s, v, (v == 0) ? 64 : 0, 0, 400);
            end
        end
        // sound 1 pure: ends at 3 ms, voice 4 must be ignored
        wr(1, 0, 64, 1, 2);
        wr(1, 4, 64, 0, 400);
        // sound 2 damped: voice 5 keeps it up to 5 ms
        wr(2, 0, 64, 1, 2);
        wr(2, 5, 64, 3, 2);
        wr_mode(2, 1'b1);
        sink_mode = 2'h2;
        fork
            for (int i = 0; i < 16; i++) push(AUDIO_W'($urandom));
            begin
                tick(80);
                chk("in_ready_full", 0, AUDIO_W'(audio_in_ready));
                sink_mode = 2'h1;
            end
        join
        drain();
        for (int k = 0; k < NUM_EVENTS; k++) fire(NUM_EVENTS'(1) << k, 4'(k));
        fire(10'h3A0, 4'h5);
        att = 1'b1;
        tick(2);
        for (int i = 0; i < 8; i++) push(AUDIO_W'($urandom));
        drain();
        att = 1'b0;
        fire(10'h002, 4'h1);
        tick(2 * MSC);
        chk("pure_mid", 1, AUDIO_W'(playing));
        tick(3 * MSC);
        chk("pure_end", 0, AUDIO_W'(playing));
        fire(10'h004, 4'h2);
        tick(4 * MSC);
        chk("damp_mid", 1, AUDIO_W'(playing));
        tick(3 * MSC);
        chk("damp_end", 0, AUDIO_W'(playing));
        sink_mode = 2'h0;
        for (int i = 0; i < 6; i++) push(AUDIO_W'($urandom));
        drain();
        complete_run();
    end
endmodule
